/* File: bsb_subscriber.v */
`timescale 1ns/10ps
`include "bsb_regs.vh"
module bsb_subscriber #(
  parameter NLINK = `BSB_NUM_LINKS,
  parameter [31:0] WD_RESET = `BSB_WD_RESET
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [1:0]  avs_response,
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  output wire        rx_ready,
  input  wire        rx_start,
  input  wire [7:0]  rx_publisher,
  input  wire        rx_end,
  input  wire        rx_error,
  input  wire        data_exchange_state,
  output reg         broadcast_output_irq
);
  // ****************************************
  // buffer storage and slot state
  // ****************************************
  reg  [7:0]  mem [0:3*`BSB_BUF_BYTES-1];
  reg  [1:0]  free_reg;
  reg  [1:0]  user_reg;
  reg  [1:0]  pend_reg;
  reg  [1:0]  wr_reg;
  reg  [7:0]  wptr_reg;
  reg  [7:0]  pub_reg;
  reg         in_frame_reg;
  reg         ctrl_en_reg;
  reg  [31:0] wd_period_reg;
  reg  [31:0] wd_cnt_reg;
  reg  [4:0]  link_sel_reg;
  reg  [7:0]  buf_addr_reg;
  wire [7:0]  link_addr [0:NLINK-1];
  wire [7:0]  link_stat [0:NLINK-1];
  reg         rd_busy_reg;
  wire [7:0]  fb_data;
  wire        fb_valid;
  wire        fb_ready;
  wire        wd_expire;
  wire        rd_take;
  wire        ctrl_wr;
  wire        wd_wr;
  wire        sel_wr;
  wire        link_wr;
  wire        addr_wr;
  genvar      g;

  // map a slot pointer and byte offset to a memory index
  function [9:0] mem_idx;
    input [1:0] ptr;
    input [7:0] off;
    begin
      mem_idx = ({8'd0, ptr} - 10'd1) * 10'd247 + {2'd0, off};
    end
  endfunction

  // answer of a request read: new flag and the user pointer after it
  // empty pending keeps user
  function [2:0] next_answer;
    input [1:0] pend;
    input [1:0] user;
    input       defer;
    begin
      if (pend != `BSB_PTR_NIL && !defer) begin
        next_answer = {1'b1, pend};
      end else begin
        next_answer = {1'b0, user};
      end
    end
  endfunction

  // status byte after a monitoring expiry
  function [7:0] expire_stat;
    input [7:0] s;
    begin
      if (s[`BSB_LS_DATA]) begin
        expire_stat = 8'h80;
      end else if (s[`BSB_LS_FAULT]) begin
        expire_stat = 8'h00;
      end else begin
        expire_stat = s;
      end
    end
  endfunction

  // length error: no payload, or more than the buffer holds
  function len_error;
    input [7:0] wptr;
    begin
      len_error = (wptr == `BSB_BYTE_DATA) ||
                  (wptr > `BSB_BYTE_LAST + 8'd1);
    end
  endfunction

  // ****************************************
  // receive path buffer
  // ****************************************
  bsb_skid #(.W(8)) u_skid (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (fb_data),
    .out_valid (fb_valid),
    .out_ready (fb_ready)
  );

  // frame end waits until buffered bytes are written
  assign fb_ready = in_frame_reg;

  // ****************************************
  // register bus decode
  // ****************************************
  // a read is taken in its first cycle, writes never wait
  assign rd_take = avs_read && !rd_busy_reg;
  // one strobe per writable register, unmapped writes fall away
  assign ctrl_wr = avs_write && (avs_address == `BSB_IDX_CTRL);
  assign wd_wr   = avs_write && (avs_address == `BSB_IDX_WD_PERIOD);
  assign sel_wr  = avs_write && (avs_address == `BSB_IDX_LINK_STAT);
  assign link_wr = avs_write && (avs_address == `BSB_IDX_LINK_ADDR);
  assign addr_wr = avs_write && (avs_address == `BSB_IDX_BUF_ADDR);

  // ****************************************
  // frame capture into write slot
  // ****************************************
  // store frame
  always @(posedge mclk) begin
    if (in_frame_reg && fb_valid && wptr_reg <= `BSB_BYTE_LAST) begin
      mem[mem_idx(wr_reg, wptr_reg)] <= fb_data;
    end
    if (rx_start && ctrl_en_reg) begin
      mem[mem_idx(wr_reg, `BSB_BYTE_PUB)] <= rx_publisher;
    end else if (in_frame_reg && rx_end && !fb_valid) begin
      mem[mem_idx(wr_reg, `BSB_BYTE_LEN)] <= wptr_reg - `BSB_BYTE_DATA;
    end
  end

  wire frame_done = in_frame_reg && rx_end && !fb_valid;
  wire len_bad    = len_error(wptr_reg);
  wire frame_ok   = frame_done && !rx_error && !len_bad;
  wire frame_bad  = frame_done && (rx_error || len_bad);
  wire req_rd     = rd_take && avs_address == `BSB_IDX_NEXT_REQ;

  // ****************************************
  // slot rotation
  // ****************************************
  // rotation, no clearing
  always @(posedge mclk) begin
    if (!rst_n) begin
      wr_reg       <= `BSB_PTR_ONE;
      pend_reg     <= `BSB_PTR_NIL;
      user_reg     <= `BSB_PTR_TWO;
      free_reg     <= `BSB_PTR_THREE;
      in_frame_reg <= 1'b0;
      wptr_reg     <= 8'd0;
      pub_reg      <= 8'd0;
      broadcast_output_irq <= 1'b0;
    end else begin
      broadcast_output_irq <= 1'b0;
      if (rx_start && ctrl_en_reg) begin
        in_frame_reg <= 1'b1;
        wptr_reg     <= `BSB_BYTE_DATA;
        pub_reg      <= rx_publisher;
      end else if (in_frame_reg && fb_valid) begin
        wptr_reg <= (wptr_reg == 8'hff) ? wptr_reg : wptr_reg + 8'd1;
      end
      if (frame_done) begin
        in_frame_reg <= 1'b0;
      end
      if (frame_ok) begin
        broadcast_output_irq <= 1'b1;
        pend_reg <= wr_reg;
        if (pend_reg != `BSB_PTR_NIL) begin
          wr_reg <= pend_reg;
        end else begin
          wr_reg   <= free_reg;
          free_reg <= `BSB_PTR_NIL;
        end
      end else if (req_rd && pend_reg != `BSB_PTR_NIL) begin
        user_reg <= pend_reg;
        pend_reg <= `BSB_PTR_NIL;
        free_reg <= user_reg;
      end
      // errored frame keeps write slot (no change above)
    end
  end

  // ****************************************
  // link status table and monitoring timer
  // ****************************************
  // watchdog interval
  assign wd_expire = data_exchange_state && (wd_cnt_reg <= 32'd1);

  // timer reloads outside data exchange and at each expiry
  always @(posedge mclk) begin
    if (!rst_n) begin
      wd_cnt_reg <= WD_RESET;
    end else if (!data_exchange_state || wd_expire) begin
      wd_cnt_reg <= wd_period_reg;
    end else begin
      wd_cnt_reg <= wd_cnt_reg - 32'd1;
    end
  end

  generate
    for (g = 0; g < NLINK; g = g + 1) begin : g_link
      reg  [7:0] addr_reg;
      reg  [7:0] stat_reg;
      wire [7:0] base;
      wire       hit;

      // expiry result first, a good reception in the same cycle builds on it (keeps bit 7), an errored one overrides it
      assign base = wd_expire ? expire_stat(stat_reg) : stat_reg;
      assign hit = (frame_ok || frame_bad) && (addr_reg == pub_reg);
      assign link_addr[g] = addr_reg;
      assign link_stat[g] = stat_reg;

      // one address and one status byte per link
      always @(posedge mclk) begin
        if (!rst_n) begin
          stat_reg <= `BSB_LS_RESET;
          addr_reg <= 8'hff;
        end else begin
          if (link_wr && (link_sel_reg == g)) begin
            addr_reg <= avs_writedata[7:0];
          end
          if (hit && frame_ok) begin
            stat_reg <= {base[7], 1'b0, base[5:1], 1'b1};
          end else if (hit) begin
            stat_reg <= 8'h40;
          end else begin
            stat_reg <= base;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // avalon slave
  // ****************************************
  // reads take one wait cycle, writes none
  assign avs_waitrequest = avs_read && !rd_busy_reg;

  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_en_reg   <= 1'b0;
      wd_period_reg <= WD_RESET;
      link_sel_reg  <= 5'd0;
      buf_addr_reg  <= 8'd0;
      rd_busy_reg   <= 1'b0;
    end else begin
      // the second cycle of a read completes it
      rd_busy_reg <= rd_take;
      if (ctrl_wr) begin
        ctrl_en_reg <= avs_writedata[0];
      end
      if (wd_wr) begin
        wd_period_reg <= avs_writedata;
      end
      if (sel_wr) begin
        link_sel_reg <= avs_writedata[4:0];
      end
      if (addr_wr) begin
        buf_addr_reg <= avs_writedata[7:0];
      end
    end
  end

  // read data registered for the second cycle of a read
  always @(posedge mclk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
      avs_response <= 2'h0;
    end else if (rd_take) begin
      avs_response <= 2'h0;
      case (avs_address)
        `BSB_IDX_ASSIGN: avs_readdata <= {24'h0, free_reg, user_reg,
                                          pend_reg, wr_reg};
        `BSB_IDX_NEXT_REQ: avs_readdata <= {29'h0,
          next_answer(pend_reg, user_reg, frame_ok)};
        `BSB_IDX_CTRL:      avs_readdata <= {31'h0, ctrl_en_reg};
        `BSB_IDX_WD_PERIOD: avs_readdata <= wd_period_reg;
        `BSB_IDX_LINK_ADDR: avs_readdata <= {24'h0,
          (link_sel_reg < NLINK) ? link_addr[link_sel_reg] : 8'h00};
        `BSB_IDX_LINK_STAT: avs_readdata <= {24'h0,
          (link_sel_reg < NLINK) ? link_stat[link_sel_reg] : 8'h00};
        `BSB_IDX_BUF_ADDR:  avs_readdata <= {24'h0, buf_addr_reg};
        `BSB_IDX_BUF_DATA:  avs_readdata <= {24'h0,
          (user_reg != `BSB_PTR_NIL && buf_addr_reg <= `BSB_BYTE_LAST) ?
          mem[mem_idx(user_reg, buf_addr_reg)] : 8'h00};
        default: begin
          avs_readdata <= 32'h0;
          avs_response <= 2'h2;
        end
      endcase
    end
  end
endmodule

/* File: bsb_regs.vh */
`ifndef BSB_REGS_VH
`define BSB_REGS_VH
// register offsets (byte address = index * 4)
`define BSB_IDX_ASSIGN     8'h12
`define BSB_IDX_NEXT_REQ   8'h13
`define BSB_IDX_CTRL       8'h20
`define BSB_IDX_WD_PERIOD  8'h21
`define BSB_IDX_LINK_ADDR  8'h22
`define BSB_IDX_LINK_STAT  8'h23
`define BSB_IDX_BUF_ADDR   8'h24
`define BSB_IDX_BUF_DATA   8'h25
// slot encodings
`define BSB_PTR_NIL        2'h0
`define BSB_PTR_ONE        2'h1
`define BSB_PTR_TWO        2'h2
`define BSB_PTR_THREE      2'h3
// assignment register fields
`define BSB_FREE_POS       6
`define BSB_USER_POS       4
`define BSB_PEND_POS       2
`define BSB_WRITE_POS      0
// next request fields
`define BSB_NEW_USER_BIT   2
// link status bits
`define BSB_LS_ACTIVE      7
`define BSB_LS_FAULT       6
`define BSB_LS_DATA        0
`define BSB_LS_RESET       8'h00
// buffer layout
`define BSB_BYTE_PUB       8'd0
`define BSB_BYTE_LEN       8'd1
`define BSB_BYTE_DATA      8'd2
`define BSB_BYTE_LAST      8'd246
`define BSB_BUF_BYTES      247
`define BSB_NUM_LINKS      29
// timing
`define BSB_CLK_MHZ        125
`define BSB_WD_PERIOD_US   1000
`define BSB_WD_RESET       32'd125000
`endif

/* File: bsb_skid.v */
`timescale 1ns/10ps
// two-entry buffer, valid/ready on both sides
module bsb_skid #(
  parameter W = 8
) (
  input  wire         mclk,
  input  wire         rst_n,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] d0_reg;
  reg [W-1:0] d1_reg;
  reg [1:0]   cnt_reg;
  wire        push;
  wire        pop;

  assign in_ready  = (cnt_reg != 2'd2);
  assign out_valid = (cnt_reg != 2'd0);
  assign out_data  = d0_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage and occupancy
  always @(posedge mclk) begin
    if (!rst_n) begin
      cnt_reg <= 2'd0;
      d0_reg  <= {W{1'b0}};
      d1_reg  <= {W{1'b0}};
    end else begin
      if (pop) begin
        d0_reg <= (cnt_reg == 2'd2) ? d1_reg : in_data;
      end else if (push && cnt_reg == 2'd0) begin
        d0_reg <= in_data;
      end
      if (push && ((cnt_reg == 2'd1 && !pop) || (cnt_reg == 2'd2))) begin
        d1_reg <= in_data;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* File: bsb_assertions.sv */
`timescale 1ns/10ps
// ****
// bus and interrupt checker
// ****
module bsb_assertions (
  input wire        mclk,
  input wire        rst_n,
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [1:0]  avs_response,
  input wire        rx_end,
  input wire        rx_error,
  input wire        broadcast_output_irq
);
  // read completing this cycle
  wire done = avs_read && !avs_waitrequest;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rd_wait; avs_read && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait too long");
  property p_wr_fast; avs_write |-> !avs_waitrequest; endproperty
  a_wr_fast: assert property (p_wr_fast)
    else $error("write stalled");
  property p_unmap;
    done && avs_address == 8'h30 |-> !avs_readdata && avs_response == 2'h2;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read");
  property p_req;
    done && avs_address == 8'h13 |-> avs_readdata[7:3] == 5'h0
      && avs_readdata[1:0] != 2'h0;
  endproperty
  a_req: assert property (p_req)
    else $error("request format");
  property p_slots; done && avs_address == 8'h12 |-> avs_readdata[1:0] != 0;
  endproperty
  a_slots: assert property (p_slots)
    else $error("no write slot");
  property p_stat; done && avs_address == 8'h23 |-> avs_readdata[5:1] == 0;
  endproperty
  a_stat: assert property (p_stat)
    else $error("status reserved bits");
  property p_pulse; broadcast_output_irq |=> !broadcast_output_irq;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("irq too wide");
  property p_cause; $rose(broadcast_output_irq) |-> $past(rx_end); endproperty
  a_cause: assert property (p_cause)
    else $error("irq without frame end");
  property p_noerr; broadcast_output_irq |-> !$past(rx_error); endproperty
  a_noerr: assert property (p_noerr)
    else $error("irq after bad frame");
  c_irq: cover property (broadcast_output_irq);
  c_new: cover property (done && avs_address == 8'h13 && avs_readdata[2]);
  c_bad: cover property (done && avs_response == 2'h2);
endmodule
bind bsb_subscriber bsb_assertions chk (.mclk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .avs_response,
  .rx_end, .rx_error, .broadcast_output_irq);

/* File: bsb_publisher.sv */
`timescale 1ns/10ps
// ****
// publisher station model
// ****
module bsb_publisher (
  input  wire       mclk,
  input  wire       rx_ready,
  output reg  [7:0] rx_data = 8'h00,
  output reg        rx_valid = 1'b0,
  output reg        rx_start = 1'b0,
  output reg  [7:0] rx_publisher = 8'h00,
  output reg        rx_end = 1'b0,
  output reg        rx_error = 1'b0
);
  reg [7:0] sent [0:255];
  // bytes that the subscriber never accepted within the bound
  integer   stalls = 0;
  // one frame: start pulse, bytes with stalls, held end
  task send(input [7:0] pub, input [7:0] n, input bad);
    integer i, k;
    begin
      rx_start <= 1'b1;
      rx_publisher <= pub;
      @(posedge mclk);
      rx_start <= 1'b0;
      rx_publisher <= ~pub;
      for (i = 0; i < n; i = i + 1) begin
        rx_data <= sent[i];
        rx_valid <= 1'b1;
        k = 0;
        do begin @(posedge mclk); k = k + 1; end while (!rx_ready && k < 99);
        if (k == 99) stalls = stalls + 1;
        // slow on odd bytes and the last one, prompt on the other even ones
        if (i[0] || i == n - 1) begin
          rx_valid <= 1'b0;
          rx_data <= ~sent[i];
          @(posedge mclk);
        end
      end
      rx_end <= 1'b1;
      rx_error <= bad;
      repeat (4) @(posedge mclk);
      rx_end <= 1'b0;
      rx_error <= 1'b0;
    end
  endtask
endmodule

/* File: bsb_subscriber_test.sv */
`timescale 1ns/10ps
// ****
// subscriber bench
// ****
module bsb_subscriber_test;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  avs_address = 8'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg         data_exchange_state = 1'b0;
  wire [31:0] avs_readdata;
  wire [1:0]  avs_response;
  wire [7:0]  rx_data, rx_publisher;
  wire        avs_waitrequest, rx_ready, rx_valid, rx_start, rx_end;
  wire        rx_error, broadcast_output_irq;
  integer     num_errors = 0, cmp_count = 0, irqs = 0, ni = 0, i, n;
  reg  [15:0] lf = 16'd31;
  reg  [31:0] rd;
  reg  [1:0]  rs, sf = 2'h3, su = 2'h2, sn = 2'h0, sw = 2'h1;
  reg  [7:0]  len;
  localparam [7:0] PUB = 8'h2c;
  // clock and units under test
  initial forever #4 mclk = ~mclk;
  bsb_subscriber #(.WD_RESET(32'd20)) dut (.mclk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .avs_response, .rx_data, .rx_valid, .rx_ready, .rx_start, .rx_publisher,
    .rx_end, .rx_error, .data_exchange_state, .broadcast_output_irq);
  bsb_publisher pub (.mclk, .rx_ready, .rx_data, .rx_valid, .rx_start,
    .rx_publisher, .rx_end, .rx_error);
  // interrupt pulse counter
  always @(posedge mclk) if (broadcast_output_irq === 1'b1) irqs <= irqs + 1;
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task wrap_up;
    begin
      if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one bus cycle, held until waitrequest is low
  task bus(input wr, input [7:0] a, input [31:0] wd);
    integer k;
    begin
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      k = 0;
      do begin @(posedge mclk); k = k + 1; end
        while (avs_waitrequest !== 1'b0 && k < 50);
      rd = avs_readdata;
      rs = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
      if (k == 50) begin num_errors = num_errors + 1; wrap_up; end
    end
  endtask
  task slots;
    begin bus(0, 8'h12, 0); chk(rd, {24'h0, sf, su, sn, sw}); end
  endtask
  task status(input [7:0] e);
    begin bus(0, 8'h23, 0); chk(rd, {24'h0, e}); end
  endtask
  // fetch and expected slot swap, then buffer contents
  task fetch;
    reg fresh;
    begin
      bus(0, 8'h13, 0);
      fresh = (sn != 2'h0);
      if (fresh) begin sf = su; su = sn; sn = 2'h0; end
      chk(rd, {29'h0, fresh, su});
      for (i = 0; fresh && i < len + 2; i = i + 1) begin
        bus(1, 8'h24, i);
        bus(0, 8'h25, 0);
        chk(rd[7:0], i == 0 ? PUB : i == 1 ? len : pub.sent[i-2]);
      end
    end
  endtask
  // send a frame and track the expected rotation
  task frame(input [7:0] l, input bad);
    begin
      for (i = 0; i < l; i = i + 1) begin
        lf = lfsr(lf);
        pub.sent[i] = lf[7:0];
      end
      pub.send(PUB, l, bad);
      repeat (2) @(posedge mclk);
      if (l != 0 && !bad) begin
        ni = ni + 1;
        if (sn != 2'h0) {sn, sw} = {sw, sn};
        else begin sn = sw; sw = sf; sf = 2'h0; end
      end
      chk(irqs, ni);
      chk(pub.stalls, 0);
      slots;
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    slots;
    fetch;
    bus(0, 8'h30, 0);
    chk({30'h0, rs}, 32'h2);
    chk(rd, 32'h0);
    bus(1, 8'h20, 1);
    bus(1, 8'h23, 0);
    bus(1, 8'h22, PUB);
    bus(1, 8'h21, 20);
    for (n = 0; n < 6; n = n + 1) begin
      lf = lfsr(lf);
      len = lf[3:0] + (n == 5 ? 8'd245 - lf[3:0] : 8'd1);
      frame(len, 1'b0);
      if (lf[4] || n == 5) fetch;
    end
    status(8'h01);
    data_exchange_state <= 1'b1;
    repeat (50) @(posedge mclk);
    status(8'h80);
    data_exchange_state <= 1'b0;
    frame(len, 1'b0);
    status(8'h81);
    frame(0, 1'b0);
    status(8'h40);
    frame(3, 1'b1);
    status(8'h40);
    data_exchange_state <= 1'b1;
    repeat (50) @(posedge mclk);
    status(8'h00);
    wrap_up;
  end
endmodule
